// File: ram_cam_pkg.sv
// Shared constants and carrier types for the dual-clock memory block
package ram_cam_pkg;

	// ----------------------------------------------------------------
	// Geometry defaults
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int DEPTH = 1 << ADDR_W;

	// ----------------------------------------------------------------
	// Product-term resources
	// ----------------------------------------------------------------
	localparam int OWN_TERMS = 2;
	localparam int EXP_PER_SET = 2;
	localparam int EXP_SETS = 15;
	localparam int EXP_TERMS = EXP_SETS * EXP_PER_SET;
	localparam int MAX_TERMS = OWN_TERMS + EXP_TERMS;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic strobe;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} write_req_t;

	typedef struct packed {
		logic strobe;
		logic cam;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] key;
	} read_req_t;

	typedef enum logic {
		RAM_READ,
		CAM_SEARCH
	} read_mode_t;

endpackage

// File: expander_or.sv
// Macrocell OR gate fed by its own terms and a chain of parallel expanders
module expander_or #(
	parameter int SETS = ram_cam_pkg::EXP_SETS
) (
	// Product terms
	input wire logic [ram_cam_pkg::OWN_TERMS-1:0] own_terms,
	input wire logic [SETS*ram_cam_pkg::EXP_PER_SET-1:0] exp_terms,
	input wire logic [SETS-1:0] set_en,
	// Result
	output logic sum_out
);

	logic [SETS:0] chain;

	assign chain[0] = |own_terms;

	// Each borrowed set adds one more OR stage, hence a small extra delay
	generate
		for (genvar i = 0; i < SETS; i++) begin : g_set
			localparam int LO = i * ram_cam_pkg::EXP_PER_SET;
			assign chain[i+1] = chain[i] | (set_en[i] &
				(|exp_terms[LO +: ram_cam_pkg::EXP_PER_SET]));
		end
	endgenerate

	assign sum_out = chain[SETS];

endmodule // expander_or

// File: embedded_memory_block.sv
// Dual-clock memory block with CAM search and product-term macrocell
//
// Contract
// - Write data, strobe and address registers run only on write clock.
// - Read strobe, address and output registers run only on read clock.
// - Each side has its own clock enable and asynchronous clear.
// - Global or chip-wide reset clears every register asynchronously; a local clear clears only its own side.
// - CAM mode returns the address holding the search word.
// - CAM search compares all locations in parallel, in one operation.
// - Match flag goes high when a search finds an equal stored word.
// - Macrocell OR combines up to 32 terms: two own, thirty expanders.
// - Up to fifteen chained expander sets, two expanders each.
module embedded_memory_block #(
	parameter int ADDR_W = ram_cam_pkg::ADDR_W,
	parameter int DATA_W = ram_cam_pkg::DATA_W,
	parameter int SETS = ram_cam_pkg::EXP_SETS
) (
	// Clocks
	input wire logic wr_clk,
	input wire logic rd_clk,
	// Clears, all asynchronous and active low
	input wire logic rst_n,
	input wire logic global_clr_n,
	input wire logic wr_clr_n,
	input wire logic rd_clr_n,
	// Clock enables
	input wire logic wr_ce,
	input wire logic rd_ce,
	// Write port
	input wire logic write_strobe,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	// Read and search port
	input wire logic read_strobe,
	input wire logic cam_mode,
	input wire logic [ADDR_W-1:0] rd_addr,
	input wire logic [DATA_W-1:0] search_word,
	output logic [DATA_W-1:0] rd_data,
	output logic [ADDR_W-1:0] match_addr,
	output logic match_flag,
	// Product-term macrocell
	input wire logic [ram_cam_pkg::OWN_TERMS-1:0] own_terms,
	input wire logic [SETS*ram_cam_pkg::EXP_PER_SET-1:0] exp_terms,
	input wire logic [SETS-1:0] set_en,
	output logic pterm_out
);

	localparam int DEPTH = 1 << ADDR_W;

	// ----------------------------------------------------------------
	// Clear distribution
	// ----------------------------------------------------------------
	// The chip-wide and global clears reach both sides; each side also
	// has a local clear of its own.
	logic wr_arst_n;
	logic rd_arst_n;

	assign wr_arst_n = rst_n & global_clr_n & wr_clr_n;
	assign rd_arst_n = rst_n & global_clr_n & rd_clr_n;

	// ----------------------------------------------------------------
	// Write side
	// ----------------------------------------------------------------
	typedef struct packed {
		logic strobe;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} wreq_t;

	wreq_t wreq_reg;
	logic [DATA_W-1:0] mem_reg [DEPTH];
	logic [DEPTH-1:0] valid_reg;

	// Input registers: data, strobe and address
	always_ff @(posedge wr_clk or negedge wr_arst_n) begin
		if (!wr_arst_n) begin
			wreq_reg <= '0;
		end else if (wr_ce) begin
			wreq_reg.strobe <= write_strobe;
			wreq_reg.addr <= wr_addr;
			wreq_reg.data <= wr_data;
		end
	end

	// Storage; a location only takes part in searches once written
	always_ff @(posedge wr_clk or negedge wr_arst_n) begin
		if (!wr_arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			valid_reg <= '0;
		end else if (wr_ce && wreq_reg.strobe) begin
			mem_reg[wreq_reg.addr] <= wreq_reg.data;
			valid_reg[wreq_reg.addr] <= 1'h1;
		end
	end

	// ----------------------------------------------------------------
	// Read side
	// ----------------------------------------------------------------
	typedef struct packed {
		logic strobe;
		logic cam;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] key;
	} rreq_t;

	rreq_t rreq_reg;
	ram_cam_pkg::read_mode_t mode;
	logic rd_take;

	assign mode = rreq_reg.cam ? ram_cam_pkg::CAM_SEARCH
		: ram_cam_pkg::RAM_READ;
	assign rd_take = rd_ce && rreq_reg.strobe;

	// Input registers: read strobe, address and search word
	always_ff @(posedge rd_clk or negedge rd_arst_n) begin
		if (!rd_arst_n) begin
			rreq_reg <= '0;
		end else if (rd_ce) begin
			rreq_reg.strobe <= read_strobe;
			rreq_reg.cam <= cam_mode;
			rreq_reg.addr <= rd_addr;
			rreq_reg.key <= search_word;
		end
	end

	// ----------------------------------------------------------------
	// Search
	// ----------------------------------------------------------------
	logic [DEPTH-1:0] hit;
	logic [ADDR_W-1:0] hit_addr;
	logic hit_any;

	// Every location has its own comparator: the search is one step
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_cmp
			assign hit[i] = valid_reg[i] &&
				(mem_reg[i] == rreq_reg.key);
		end
	endgenerate

	// Lowest matching address wins when a word is stored more than once
	function automatic logic [ADDR_W-1:0] first_hit(
		input logic [DEPTH-1:0] v
	);
		logic [ADDR_W-1:0] a;
		a = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (v[i]) begin
				a = ADDR_W'(i);
			end
		end
		return a;
	endfunction

	assign hit_addr = first_hit(hit);
	assign hit_any = |hit;

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	// The array is read across clocks, so the user must not read a
	// location in the same cycle it is being written.

	// Read data: only a RAM read moves it
	always_ff @(posedge rd_clk or negedge rd_arst_n) begin
		if (!rd_arst_n) begin
			rd_data <= '0;
		end else if (rd_take) begin
			case (mode)
				ram_cam_pkg::RAM_READ: begin
					rd_data <= mem_reg[rreq_reg.addr];
				end
				default: begin
					rd_data <= rd_data;
				end
			endcase
		end
	end

	// Search result: only a search moves it
	always_ff @(posedge rd_clk or negedge rd_arst_n) begin
		if (!rd_arst_n) begin
			match_addr <= '0;
			match_flag <= 1'h0;
		end else if (rd_take) begin
			case (mode)
				ram_cam_pkg::CAM_SEARCH: begin
					match_addr <= hit_addr;
					match_flag <= hit_any;
				end
				default: begin
					match_addr <= match_addr;
					match_flag <= match_flag;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Product-term macrocell
	// ----------------------------------------------------------------
	logic pterm_sum;

	expander_or #(
		.SETS(SETS)
	) u_expander_or (
		.own_terms(own_terms),
		.exp_terms(exp_terms),
		.set_en(set_en),
		.sum_out(pterm_sum)
	);

	always_ff @(posedge rd_clk or negedge rd_arst_n) begin
		if (!rd_arst_n) begin
			pterm_out <= 1'h0;
		end else if (rd_ce) begin
			pterm_out <= pterm_sum;
		end
	end

endmodule // embedded_memory_block

// File: emb_props.sv
// Read-side port checks for the memory block
module emb_props #(
	parameter int ADDR_W = ram_cam_pkg::ADDR_W,
	parameter int DATA_W = ram_cam_pkg::DATA_W,
	parameter int SETS = ram_cam_pkg::EXP_SETS
) (
	// Clock and clears
	input wire logic rd_clk,
	input wire logic rst_n,
	input wire logic global_clr_n,
	input wire logic rd_clr_n,
	// Read port
	input wire logic rd_ce,
	input wire logic read_strobe,
	input wire logic cam_mode,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic [ADDR_W-1:0] match_addr,
	input wire logic match_flag,
	// Product terms
	input wire logic [1:0] own_terms,
	input wire logic [2*SETS-1:0] exp_terms,
	input wire logic [SETS-1:0] set_en,
	input wire logic pterm_out
);
	timeunit 1ns;
	timeprecision 100ps;
	wire rd_ok = rst_n & global_clr_n & rd_clr_n;
	logic pexp;
	// Each set gates only its own pair of expander terms
	always_comb begin
		pexp = |own_terms;
		for (int s = 0; s < SETS; s++)
			pexp = pexp | (set_en[s] & (|exp_terms[2*s +: 2]));
	end
	default clocking cb @(posedge rd_clk); endclocking
	default disable iff (!rd_ok);
	property p_clr; $rose(rd_ok) |-> !(|rd_data) && !match_flag; endproperty
	a_clr: assert property (p_clr) else $error("not cleared");
	property p_hold; !rd_ce |=> $stable({rd_data, match_flag}); endproperty
	a_hold: assert property (p_hold) else $error("not frozen");
	property p_rd; $changed(rd_data) |-> $past(rd_ce); endproperty
	a_rd: assert property (p_rd) else $error("data moved");
	property p_chg; $changed(match_flag) |-> $past(rd_ce); endproperty
	a_chg: assert property (p_chg) else $error("flag moved");
	property p_miss; !match_flag |-> match_addr == '0; endproperty
	a_miss: assert property (p_miss) else $error("stray addr");
	property p_pt; rd_ce |=> pterm_out == $past(pexp); endproperty
	a_pt: assert property (p_pt) else $error("pterm");
	property p_hit;
		$rose(match_flag) && $past(rd_ce) && $past(rd_ce, 2)
			|-> $past(read_strobe && cam_mode, 2);
	endproperty
	a_hit: assert property (p_hit) else $error("hit w/o search");
	property p_cam;
		rd_ce && read_strobe && cam_mode ##1 rd_ce |=> $stable(rd_data);
	endproperty
	a_cam: assert property (p_cam) else $error("search read");
endmodule // emb_props

bind embedded_memory_block emb_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
	.SETS(SETS)) emb_props_i (.*);

// File: fabric_user.sv
// User-logic model that loads the write port
module fabric_user (
	// Clock
	input wire logic wr_clk,
	// Write port
	output logic wr_ce,
	output logic write_strobe,
	output logic [3:0] wr_addr,
	output logic [15:0] wr_data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {wr_ce, write_strobe, wr_addr, wr_data} = {1'h1, 1'h0, 4'h0,
		16'hffff};
	// Released lines show the inverse so a stale word never looks fresh
	task automatic put(input logic [3:0] a, input logic [15:0] d,
		input logic ce, input int gap);
		@(posedge wr_clk) #1;
		{wr_ce, write_strobe, wr_addr, wr_data} = {ce, 1'h1, a, d};
		@(posedge wr_clk) #1;
		{write_strobe, wr_addr, wr_data} = {1'h0, ~a, ~d};
		repeat (gap) @(posedge wr_clk);
		#1 wr_ce = 1'h1;
	endtask
endmodule // fabric_user

// File: embedded_memory_block_test.sv
// Self-checking bench for the memory block
module embedded_memory_block_test;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic c;
		logic [3:0] a;
		logic [15:0] k;
		logic [15:0] e;
	} row_t;
	// CAM rows expect {flag, 11 zero bits, address}
	row_t rows [6] = '{'{1'h0, 4'h5, 16'h0, 16'h0},
		'{1'h0, 4'h3, 16'h0, 16'hfa12}, '{1'h1, 4'h0, 16'h0, 16'h0},
		'{1'h1, 4'h0, 16'hbeef, 16'h0}, '{1'h1, 4'h0, 16'h5a5a, 16'h8009},
		'{1'h1, 4'h0, 16'hfa12, 16'h8003}};
	logic clk = 1'h0, wr_clk = 1'h0, rst_n = 1'h0, global_clr_n = 1'h1;
	logic wr_clr_n = 1'h1, rd_clr_n = 1'h1, rd_ce = 1'h1, read_strobe = 1'h0;
	logic cam_mode = 1'h0, wr_ce, write_strobe, match_flag, pterm_out;
	logic [3:0] rd_addr = 4'h0, wr_addr, match_addr;
	logic [15:0] search_word = 16'h0, wr_data, rd_data;
	logic [1:0] own_terms = 2'h0;
	logic [29:0] exp_terms = 30'h0;
	logic [14:0] set_en = 15'h0;
	int num_errors = 0, num_checks = 0;
	always #10 clk = ~clk;
	always #13 wr_clk = ~wr_clk;
	embedded_memory_block embedded_memory_block_i (.rd_clk(clk), .*);
	fabric_user fabric_user_i (.*);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rq(input logic c, input logic [3:0] a,
		input logic [15:0] k);
		@(posedge clk) #1;
		{read_strobe, cam_mode, rd_addr, search_word} = {1'h1, c, a, k};
		@(posedge clk) #1;
		{read_strobe, search_word} = {1'h0, ~k};
		@(posedge clk) #1;
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#20us;
		num_errors++;
		$display("mismatch at %0t: timeout", $time);
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1'h1;
		fabric_user_i.put(4'h3, 16'hfa12, 1'h1, 0);
		fabric_user_i.put(4'he, 16'hfa12, 1'h1, 3);
		fabric_user_i.put(4'h9, 16'h5a5a, 1'h1, 0);
		fabric_user_i.put(4'h6, 16'hbeef, 1'h0, 2);
		repeat (4) @(posedge clk);
		foreach (rows[i]) begin
			rq(rows[i].c, rows[i].a, rows[i].k);
			if (rows[i].c)
				chk({match_flag, 11'h0, match_addr}, rows[i].e);
			else
				chk(rd_data, rows[i].e);
		end
		rd_ce = 1'h0;
		rq(1'h0, 4'h9, 16'h0);
		chk(rd_data, 16'hfa12);
		rd_ce = 1'h1;
		{own_terms, exp_terms, set_en} = {2'h0, 30'h20000000, 15'h4000};
		@(posedge clk) #1;
		chk({15'h0, pterm_out}, 16'h1);
		set_en = 15'h3fff;
		@(posedge clk) #1;
		chk({15'h0, pterm_out}, 16'h0);
		rd_clr_n = 1'h0;
		#1 chk(rd_data | {15'h0, match_flag}, 16'h0);
		#1 rd_clr_n = 1'h1;
		wr_clr_n = 1'h0;
		#1 wr_clr_n = 1'h1;
		rq(1'h1, 4'h0, 16'hfa12);
		chk({match_flag, 11'h0, match_addr}, 16'h0);
		fabric_user_i.put(4'h7, 16'h1234, 1'h1, 0);
		rq(1'h1, 4'h0, 16'h1234);
		chk({match_flag, 11'h0, match_addr}, 16'h8007);
		global_clr_n = 1'h0;
		#1 chk({match_flag, 11'h0, match_addr}, 16'h0);
		#1 global_clr_n = 1'h1;
		rq(1'h1, 4'h0, 16'h1234);
		chk({match_flag, 11'h0, match_addr}, 16'h0);
		wrap_up();
	end
endmodule // embedded_memory_block_test
